/* File: core/ccc_activity.sv */
// Sync activity detector: active while an edge was seen within the timeout window.
module ccc_activity #(
  parameter int TIMEOUT = 4000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level_in,
  output logic      active
);

  logic        prev;
  logic [15:0] count;

  // Each edge reloads the window; silence lets it run out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev   <= 1'b0;
      count  <= 16'h0000;
      active <= 1'b0;
    end else begin
      prev <= level_in;
      if (level_in != prev) begin
        count  <= 16'(TIMEOUT);
        active <= 1'b1;
      end else if (count != 16'h0000) begin
        count  <= count - 16'h0001;
        active <= (count != 16'h0001);
      end
    end
  end

endmodule

/* File: core/ccc_pkg.sv */
// Package with register map, field positions, reset values and timing for clamp/sync config.
package ccc_pkg;

  // ----------------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------------
  localparam logic [5:0] IDX_CLAMP_SRC     = 6'h18;
  localparam logic [5:0] IDX_PLACEMENT     = 6'h19;
  localparam logic [5:0] IDX_DURATION      = 6'h1A;
  localparam logic [5:0] IDX_CLAMP_OFFSET  = 6'h1B;
  localparam logic [5:0] IDX_TEST_ONES     = 6'h1C;
  localparam logic [5:0] IDX_SLICED_SYNC   = 6'h1D;
  localparam logic [5:0] IDX_POWER_CHANNEL = 6'h1E;

  // ----------------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RST_CLAMP_SRC     = 8'h00;
  localparam logic [7:0] RST_PLACEMENT     = 8'h08;
  localparam logic [7:0] RST_DURATION      = 8'h20;
  localparam logic [7:0] RST_CLAMP_OFFSET  = 8'h53;
  localparam logic [7:0] RST_TEST_ONES     = 8'hFF;
  localparam logic [7:0] RST_SLICED_SYNC   = 8'h78;
  localparam logic [7:0] RST_POWER_CHANNEL = 8'h30;

  // ----------------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------------
  localparam int BIT_CLAMP_EXT   = 4;
  localparam int BIT_MID_RED     = 3;
  localparam int BIT_MID_GREEN   = 2;
  localparam int BIT_MID_BLUE    = 1;
  localparam int BIT_EXT_POL_OVR = 7;
  localparam int BIT_EXT_POL     = 6;
  localparam int BIT_AUTO_OFS    = 5;
  localparam int POS_RATE_LO     = 3;
  localparam int BIT_SLICE_POL   = 2;
  localparam int POS_SLICE_SEL   = 0;
  localparam int BIT_CHAN_OVR    = 7;
  localparam int BIT_CHAN_SEL    = 6;
  localparam int BIT_PD_AUTO     = 4;

  // ----------------------------------------------------------------------------
  // Auto-offset rates, bus responses and timing.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RATE_N0       = 8'h03;
  localparam logic [7:0] RATE_N1       = 8'h30;
  localparam logic [7:0] RATE_N2       = 8'hC0;
  localparam logic [7:0] RATE_NV       = 8'h03;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;
  localparam int         CLK_HZ        = 40_000_000;
  localparam int         ACT_TIMEOUT_US = 100;
  localparam int         ACT_TIMEOUT_CYC = ACT_TIMEOUT_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic [7:0]  clamp_src;
    logic [7:0]  placement;
    logic [7:0]  duration;
    logic [7:0]  clamp_offset;
    logic [7:0]  test_ones;
    logic [7:0]  sliced;
    logic [7:0]  power;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        hs_prev;
    logic        vs_prev;
    logic        clamp_prev;
    logic        ext_pol_auto;
    logic        placing;
    logic        clamping;
    logic [7:0]  place_cnt;
    logic [7:0]  dur_cnt;
    logic [7:0]  ofs_cnt;
    logic        ofs_pulse;
    logic        clamp_out;
    logic        chan;
    logic        sliced_out;
  } ccc_state_t;

endpackage

/* File: core/ccc_sync2.sv */
// Two-stage synchroniser for a vector of asynchronous pin inputs.
module ccc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_stage <= '0;
      sync_out    <= '0;
    end else begin
      first_stage <= async_in;
      sync_out    <= first_stage;
    end
  end

endmodule

/* File: core/ccc_top.sv */
// Clamp, auto-offset, sliced sync and channel-select configuration with AXI4-Lite access.
//
// Notes on behaviour
// - Clamp source bit 4 picks the internal hsync-derived clamp when clear, external when set.
// - Bits 3, 2 and 1 clamp red, green and blue to ground when clear, to midscale when set.
// - The placement value (default 8) starts the clamp that many clocks plus 2 after the synchronised hsync trailing edge.
// - The duration value (default 32) sets how many clocks the generated clamp stays active.
// - External clamp polarity is found automatically unless the override bit is set.
// - With override bit 7 set, polarity bit 0 means active low external clamp, 1 active high.
// - Auto-offset bit 5 disables offset correction when clear and enables it when set.
// - The rate field runs correction every 3, 48 or 192 clamps, or every 3 vertical syncs.
// - Sliced sync polarity bit 2 makes the output active low when clear, active high when set.
// - Select field 1:0 routes green sync, raw hsync, regenerated or filtered sync to the output.
// - Channel override bit 7 clear lets the block choose the channel, set defers to bit 6.
// - Channel bit 6 applies on override or with syncs on both inputs, choosing channel 0 or 1.
// - Power-down select bit 4 picks manual control when clear, automatic when set, default set.
module ccc_top
  import ccc_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int TIMEOUT = ccc_pkg::ACT_TIMEOUT_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              horizontal_sync_input_zero,
  input  wire logic              horizontal_sync_input_one,
  input  wire logic              green_sync_input_zero,
  input  wire logic              green_sync_input_one,
  input  wire logic              vertical_sync_input,
  input  wire logic              external_clamp_input,
  input  wire logic              regenerated_sync,
  input  wire logic              filtered_sync,
  output logic                   clamp_active,
  output logic                   clamp_midscale_red,
  output logic                   clamp_midscale_green,
  output logic                   clamp_midscale_blue,
  output logic                   auto_offset_enable,
  output logic                   auto_offset_update,
  output logic                   sliced_sync_output,
  output logic                   channel_select,
  output logic                   power_down_auto
);

  import ccc_pkg::*;

  ccc_state_t s;
  ccc_state_t next_s;
  logic [5:0] pins;
  logic       act0;
  logic       act1;

  // ------------------------------------------------------------------------------
  // Pin synchronisers and sync activity detection
  // ------------------------------------------------------------------------------
  ccc_sync2 #(.WIDTH(6)) u_pins (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({vertical_sync_input, external_clamp_input, green_sync_input_one,
                green_sync_input_zero, horizontal_sync_input_one,
                horizontal_sync_input_zero}),
    .sync_out (pins)
  );

  ccc_activity #(.TIMEOUT(TIMEOUT)) u_act0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level_in (pins[0] | pins[2]),
    .active   (act0)
  );

  ccc_activity #(.TIMEOUT(TIMEOUT)) u_act1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level_in (pins[1] | pins[3]),
    .active   (act1)
  );

  logic       hs_sel;
  logic       gs_sel;
  logic       vs;
  logic       ext_raw;
  logic       ext_pol;
  logic       ext_on;
  logic       do_wr;
  logic       do_rd;
  logic [5:0] widx;
  logic [5:0] ridx;
  logic [7:0] rate_n;
  logic       ofs_event;
  logic       slice_src;

  // Selected channel's syncs and the normalised external clamp.
  always_comb begin
    hs_sel  = s.chan ? pins[1] : pins[0];
    gs_sel  = s.chan ? pins[3] : pins[2];
    ext_raw = pins[4];
    vs      = pins[5];
    ext_pol = s.clamp_offset[BIT_EXT_POL_OVR] ? s.clamp_offset[BIT_EXT_POL] : s.ext_pol_auto;
    ext_on  = ext_pol ? ext_raw : ~ext_raw;
  end

  // ------------------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------------------
  // Address and data are taken together; this holds the write path to one beat.
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s.bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid & ~s.rvalid;
  assign do_wr         = s_axi_awready;
  assign do_rd         = s_axi_arready;
  assign widx          = s_axi_awaddr[7:2];
  assign ridx          = s_axi_araddr[7:2];

  // Auto-offset rate target and the event that it counts.
  always_comb begin
    unique case (s.clamp_offset[POS_RATE_LO+1:POS_RATE_LO])
      2'h0: rate_n = RATE_N0;
      2'h1: rate_n = RATE_N1;
      2'h2: rate_n = RATE_N2;
      2'h3: rate_n = RATE_NV;
    endcase
    if (s.clamp_offset[POS_RATE_LO+1:POS_RATE_LO] == 2'h3) begin
      ofs_event = vs & ~s.vs_prev;
    end else begin
      ofs_event = s.clamp_out & ~s.clamp_prev;
    end
    unique case (s.sliced[POS_SLICE_SEL+1:POS_SLICE_SEL])
      2'h0: slice_src = gs_sel;
      2'h1: slice_src = hs_sel;
      2'h2: slice_src = regenerated_sync;
      2'h3: slice_src = filtered_sync;
    endcase
  end

  // ------------------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------------------
  always_comb begin
    next_s            = s;
    next_s.hs_prev    = hs_sel;
    next_s.vs_prev    = vs;
    next_s.clamp_prev = s.clamp_out;

    // register writes, low byte lane only
    if (do_wr && s_axi_wstrb[0]) begin
      unique case (widx)
        IDX_CLAMP_SRC:     next_s.clamp_src    = s_axi_wdata[7:0];
        IDX_PLACEMENT:     next_s.placement    = s_axi_wdata[7:0];
        IDX_DURATION:      next_s.duration     = s_axi_wdata[7:0];
        IDX_CLAMP_OFFSET:  next_s.clamp_offset = s_axi_wdata[7:0];
        IDX_TEST_ONES:     next_s.test_ones    = s_axi_wdata[7:0];
        IDX_SLICED_SYNC:   next_s.sliced       = s_axi_wdata[7:0];
        IDX_POWER_CHANNEL: next_s.power        = s_axi_wdata[7:0];
        default:           next_s.power        = s.power;
      endcase
    end
    if (do_wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = (widx >= IDX_CLAMP_SRC && widx <= IDX_POWER_CHANNEL) ? RESP_OKAY
                                                                          : RESP_DECERR;
    end else if (s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // read-back of stored values; unmapped reads as zero with an error
    if (do_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      unique case (ridx)
        IDX_CLAMP_SRC:     next_s.rdata = {24'h000000, s.clamp_src};
        IDX_PLACEMENT:     next_s.rdata = {24'h000000, s.placement};
        IDX_DURATION:      next_s.rdata = {24'h000000, s.duration};
        IDX_CLAMP_OFFSET:  next_s.rdata = {24'h000000, s.clamp_offset};
        IDX_TEST_ONES:     next_s.rdata = {24'h000000, s.test_ones};
        IDX_SLICED_SYNC:   next_s.rdata = {24'h000000, s.sliced};
        IDX_POWER_CHANNEL: next_s.rdata = {24'h000000, s.power};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Auto polarity: the external clamp level at the hsync leading edge is its idle level.
    if (hs_sel && !s.hs_prev) begin
      next_s.ext_pol_auto = ~ext_raw;
    end

    // count placement clocks from the hsync trailing edge
    // then hold the clamp for the duration count
    if (!hs_sel && s.hs_prev) begin
      next_s.placing   = 1'b1;
      next_s.clamping  = 1'b0;
      next_s.place_cnt = s.placement;
    end else if (s.placing) begin
      if (s.place_cnt == 8'h00) begin
        next_s.placing  = 1'b0;
        next_s.clamping = (s.duration != 8'h00);
        next_s.dur_cnt  = s.duration;
      end else begin
        next_s.place_cnt = s.place_cnt - 8'h01;
      end
    end else if (s.clamping) begin
      next_s.dur_cnt  = s.dur_cnt - 8'h01;
      next_s.clamping = (s.dur_cnt != 8'h01);
    end

    next_s.clamp_out = s.clamp_src[BIT_CLAMP_EXT] ? ext_on : next_s.clamping;

    // pulse once per rate count of events
    next_s.ofs_pulse = 1'b0;
    if (!s.clamp_offset[BIT_AUTO_OFS]) begin
      next_s.ofs_cnt = 8'h00;
    end else if (ofs_event) begin
      if (s.ofs_cnt + 8'h01 >= rate_n) begin
        next_s.ofs_cnt   = 8'h00;
        next_s.ofs_pulse = 1'b1;
      end else begin
        next_s.ofs_cnt = s.ofs_cnt + 8'h01;
      end
    end

    // programmed bit on override or with syncs on both inputs
    if (s.power[BIT_CHAN_OVR] || (act0 && act1)) begin
      next_s.chan = s.power[BIT_CHAN_SEL];
    end else begin
      next_s.chan = act1;
    end

    next_s.sliced_out = s.sliced[BIT_SLICE_POL] ? slice_src : ~slice_src;
  end

  // ------------------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s              <= '0;
      s.clamp_src    <= RST_CLAMP_SRC;
      s.placement    <= RST_PLACEMENT;
      s.duration     <= RST_DURATION;
      s.clamp_offset <= RST_CLAMP_OFFSET;
      s.test_ones    <= RST_TEST_ONES;
      s.sliced       <= RST_SLICED_SYNC;
      s.power        <= RST_POWER_CHANNEL;
      s.sliced_out   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state flip-flops.
  assign s_axi_bvalid         = s.bvalid;
  assign s_axi_bresp          = s.bresp;
  assign s_axi_rvalid         = s.rvalid;
  assign s_axi_rresp          = s.rresp;
  assign s_axi_rdata          = s.rdata;
  assign clamp_active         = s.clamp_out;
  assign clamp_midscale_red   = s.clamp_src[BIT_MID_RED];
  assign clamp_midscale_green = s.clamp_src[BIT_MID_GREEN];
  assign clamp_midscale_blue  = s.clamp_src[BIT_MID_BLUE];
  assign auto_offset_enable   = s.clamp_offset[BIT_AUTO_OFS];
  assign auto_offset_update   = s.ofs_pulse;
  assign sliced_sync_output   = s.sliced_out;
  assign channel_select       = s.chan;
  assign power_down_auto      = s.power[BIT_PD_AUTO];

  // ------------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ext_clamp_follow_a: assert property (
    s.clamp_src[BIT_CLAMP_EXT] && $past(s.clamp_src[BIT_CLAMP_EXT]) |=> clamp_active == $past(ext_on))
    else $error("External clamp not followed.");
  mid_level_write_a: assert property (
    do_wr && s_axi_wstrb[0] && widx == IDX_CLAMP_SRC
    |=> clamp_midscale_red == $past(s_axi_wdata[3]) && clamp_midscale_blue == $past(s_axi_wdata[1]))
    else $error("Clamp level select not applied.");
  place_start_a: assert property (
    s.placing && s.place_cnt == 8'h00 && s.duration != 8'h00 && !(!hs_sel && s.hs_prev)
    |=> s.clamping)
    else $error("Clamp did not start after placement.");
  dur_end_a: assert property (
    s.clamping && s.dur_cnt == 8'h01 && !s.placing && !(!hs_sel && s.hs_prev) |=> !s.clamping)
    else $error("Clamp outlasted its duration.");
  pol_override_a: assert property (
    s.clamp_src[BIT_CLAMP_EXT] && s.clamp_offset[BIT_EXT_POL_OVR]
    |=> clamp_active == ($past(s.clamp_offset[BIT_EXT_POL]) ? $past(ext_raw) : !$past(ext_raw)))
    else $error("Programmed clamp polarity ignored.");
  ofs_off_a: assert property (
    !s.clamp_offset[BIT_AUTO_OFS] |=> !auto_offset_update)
    else $error("Offset update while disabled.");
  ofs_rate_a: assert property (
    auto_offset_update |-> $past(s.ofs_cnt) + 8'h01 == rate_n)
    else $error("Offset update at wrong count.");
  slice_hsync_a: assert property (
    s.sliced[1:0] == 2'h1 && s.sliced[BIT_SLICE_POL] |=> sliced_sync_output == $past(hs_sel))
    else $error("Sliced output not raw hsync.");
  chan_override_a: assert property (
    s.power[BIT_CHAN_OVR] |=> channel_select == $past(s.power[BIT_CHAN_SEL]))
    else $error("Channel override ignored.");
  read_back_a: assert property (
    do_rd && ridx == IDX_PLACEMENT |=> s_axi_rdata[7:0] == $past(s.placement) && s_axi_rvalid)
    else $error("Read-back mismatch.");

endmodule

/* File: sim/ccc_top_tb_top.sv */
// Self-checking testbench for the clamp, sync and channel configuration block.
module ccc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccc_pkg::*;

  // ----------------------------------------------------------------------------
  // Signals and design instance.
  // ----------------------------------------------------------------------------
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rval;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        hs0 = 0, hs1 = 0, gs0 = 0, gs1 = 0, vs = 0, ext = 0, regen = 0, filt = 0;
  logic        clamp, red, green, blue, ofs_en, ofs_upd, sliced, chan, pd_auto;
  int          errors = 0, checks = 0, updates = 0, d1, d2, w;

  ccc_top #(.ADDR_W(8), .TIMEOUT(20)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .horizontal_sync_input_zero(hs0), .horizontal_sync_input_one(hs1),
    .green_sync_input_zero(gs0), .green_sync_input_one(gs1),
    .vertical_sync_input(vs), .external_clamp_input(ext),
    .regenerated_sync(regen), .filtered_sync(filt),
    .clamp_active(clamp), .clamp_midscale_red(red), .clamp_midscale_green(green),
    .clamp_midscale_blue(blue), .auto_offset_enable(ofs_en), .auto_offset_update(ofs_upd),
    .sliced_sync_output(sliced), .channel_select(chan), .power_down_auto(pd_auto)
  );

  // The clock runs at 40 MHz; the update pulse is counted on every rising edge.
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (ofs_upd === 1'b1) updates++;
  end

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Both write channels are offered together and dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    @(negedge aclk);
    while (awready !== 1'b1 || wready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    d = rdata; resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // One hsync pulse; delay to clamp start and clamp length are measured in cycles.
  task automatic line(output int dly, output int dur);
    @(posedge aclk) hs0 <= 1'b1;
    repeat (4) @(posedge aclk);
    hs0 <= 1'b0;
    dly = 0; dur = 0;
    while (clamp !== 1'b1 && dly < 300) begin @(negedge aclk); dly++; end
    while (clamp === 1'b1 && dur < 300) begin @(negedge aclk); dur++; end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #500000;
    errors++;
    results;
  end

  // ----------------------------------------------------------------------------
  // Register rows: byte address, value written, value read back, response.
  // ----------------------------------------------------------------------------
  typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r; } ccc_row_t;
  ccc_row_t rows [8] = '{
    '{8'h60, 32'hFFFF_FF0E, 32'h0000_000E, RESP_OKAY}, '{8'h64, 32'h0000_00A5, 32'hA5, RESP_OKAY},
    '{8'h68, 32'h0000_0005, 32'h05, RESP_OKAY}, '{8'h6C, 32'h0000_0023, 32'h23, RESP_OKAY},
    '{8'h70, 32'h0000_00FF, 32'hFF, RESP_OKAY}, '{8'h74, 32'h0000_007B, 32'h7B, RESP_OKAY},
    '{8'h78, 32'h0000_00C0, 32'hC0, RESP_OKAY}, '{8'h7C, 32'h0000_0055, 32'h00, RESP_DECERR}};
  logic [7:0] dflt [7] = '{RST_CLAMP_SRC, RST_PLACEMENT, RST_DURATION, RST_CLAMP_OFFSET,
                           RST_TEST_ONES, RST_SLICED_SYNC, RST_POWER_CHANNEL};

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pd_auto", 1, pd_auto);
    // Reset values of every register.
    for (int i = 0; i < 7; i++) begin
      rd(8'h60 + 8'(4 * i), rval);
      chk("reset value", {24'h0, dflt[i]}, rval);
    end
    // Write then read back each row, unmapped last.
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", rows[i].r, resp);
      rd(rows[i].a, rval);
      chk("rdata", rows[i].e, rval);
      chk("rresp", rows[i].r, resp);
    end
    chk("midscale", 3'b111, {red, green, blue});
    chk("ofs_en", 1, ofs_en);
    chk("chan override", 1, chan);
    chk("pd manual", 0, pd_auto);
    wr(8'h60, 32'h08);
    wr(8'h78, 32'h00);
    repeat (2) @(posedge aclk);
    chk("midscale", 3'b100, {red, green, blue});
    chk("chan auto", 0, chan);
    $display("test registers done");

    // Placement changes the delay one for one, duration sets the length.
    wr(8'h64, 32'h03);
    line(d1, w);
    chk("duration", 5, w);
    wr(8'h64, 32'h0A);
    line(d2, w);
    chk("placement", 7, d2 - d1);
    $display("test clamp timing done");

    // Updates every 3, 48 and 192 clamps; none while disabled.
    wr(8'h64, 32'h01);
    wr(8'h6C, 32'h03);
    updates = 0;
    repeat (3) line(d1, w);
    chk("no update", 0, updates);
    wr(8'h6C, 32'h23);
    repeat (7) line(d1, w);
    chk("rate 3", 2, updates);
    wr(8'h6C, 32'h03);
    wr(8'h6C, 32'h2B);
    updates = 0;
    repeat (48) line(d1, w);
    chk("rate 48", 1, updates);
    wr(8'h6C, 32'h03);
    wr(8'h6C, 32'h33);
    updates = 0;
    repeat (192) line(d1, w);
    chk("rate 192", 1, updates);
    // Rate 11 counts synchronised vertical sync rising edges instead of clamps.
    wr(8'h6C, 32'h03);
    wr(8'h6C, 32'h3B);
    updates = 0;
    repeat (6) begin
      @(posedge aclk) vs <= 1'b1;
      repeat (3) @(posedge aclk);
      vs <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    chk("rate vsync", 2, updates);
    $display("test auto offset done");

    // External clamp with programmed polarity high then low.
    wr(8'h60, 32'h10);
    wr(8'h6C, 32'hC3);
    @(posedge aclk) ext <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("ext high", 1, clamp);
    wr(8'h6C, 32'h83);
    repeat (2) @(posedge aclk);
    chk("ext low", 0, clamp);
    // Without override the pin level at the hsync leading edge is taken as idle.
    wr(8'h6C, 32'h03);
    line(d1, w);
    chk("ext auto idle", 0, clamp);
    @(posedge aclk) ext <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("ext auto on", 1, clamp);
    $display("test external clamp done");

    // Every source and both polarities of the sliced output.
    wr(8'h60, 32'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h74, 32'h78 | 32'(k));
      for (int v = 0; v < 2; v++) begin
        @(posedge aclk);
        {filt, regen, hs0, gs0} <= 4'(v) << k[1:0];
        repeat (5) @(posedge aclk);
        chk("sliced", (k >= 4) ? v : 1 - v, sliced);
      end
    end
    $display("test sliced output done");

    // Only channel one shows activity once channel zero has gone quiet.
    repeat (30) @(posedge aclk);
    repeat (4) begin
      @(posedge aclk) hs1 <= 1'b1;
      repeat (3) @(posedge aclk);
      hs1 <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    chk("chan one", 1, chan);
    // Syncs on both channels hand the choice back to the programmed bit, here zero.
    repeat (4) begin
      @(posedge aclk) {hs0, hs1} <= 2'b11;
      repeat (3) @(posedge aclk);
      {hs0, hs1} <= 2'b00;
    end
    repeat (2) @(posedge aclk);
    chk("chan both", 0, chan);
    $display("test channel done");
    results;
  end
endmodule
